// ==== logic/mlr_carrier_wd.sv ====
// Watchdog that cuts RF when carrier stays on too long
`timescale 1ns/1ns
`default_nettype none
module mlr_carrier_wd
	import mlr_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          carrier_on,
	input  wire logic [TW-1:0] limit,
	output logic               rf_cut
);
	logic [TW-1:0] on_q;
	logic          cut_q;

	// Latched cut stays until reset; a stuck carrier needs a fresh start
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			on_q  <= '0;
			cut_q <= 1'b0;
		end
		else
		begin
			on_q <= carrier_on ? on_q + 32'h1 : '0;
			if (carrier_on && on_q >= limit)
				cut_q <= 1'b1;
		end
	end
	assign rf_cut = cut_q;

	property p_wd_cut;
		@(posedge ref_clk) disable iff (rst)
			carrier_on && on_q >= limit |=> rf_cut;
	endproperty
	a_wd_cut: assert property (p_wd_cut)
		else $error("carrier watchdog did not cut");
endmodule
`default_nettype wire

// ==== logic/mlr_pkg.sv ====
// Package of constants and types for the MAC message-loss recovery block
package mlr_pkg;
	localparam int CLK_MHZ = 100;
	// Default times; all but the burst limit are loaded into a timer each time it is started
	localparam int LOST_SYNC_MS = 600;
	localparam int T1_MS        = 2000;
	localparam int RNG_RSP_MS   = 200;
	localparam int REG_RSP_MS   = 3000;
	localparam int MAX_BURST_US = 10000;
	localparam logic [31:0] LOST_SYNC_CYC = 32'(LOST_SYNC_MS * CLK_MHZ * 1000);
	localparam logic [31:0] T1_CYC        = 32'(T1_MS * CLK_MHZ * 1000);
	localparam logic [31:0] RNG_RSP_CYC   = 32'(RNG_RSP_MS * CLK_MHZ * 1000);
	localparam logic [31:0] REG_RSP_CYC   = 32'(REG_RSP_MS * CLK_MHZ * 1000);
	localparam logic [31:0] MAX_BURST_CYC = 32'(MAX_BURST_US * CLK_MHZ);
	localparam logic [3:0]  RNG_RETRIES   = 4'hf;
	localparam logic [3:0]  REG_RETRIES   = 4'h3;
	localparam int TW = 32;

	// Downstream message events, one-cycle pulses
	typedef struct packed {
		logic       sync_rx;
		logic       ucd_rx;
		logic       ucd_usable;
		logic [7:0] ucd_ccc;
		logic       map_rx;
		logic [7:0] map_ucd_cnt;
		logic       map_lost;
		logic [31:0] map_span;
		logic       rng_rsp_rx;
		logic       reg_rsp_rx;
		logic       crc_ok;
	} mlr_rx_t;

	typedef enum logic [2:0] {
		ST_SCAN    = 3'b000,
		ST_UPARAM  = 3'b001,
		ST_RANGE   = 3'b010,
		ST_REG     = 3'b011,
		ST_OPER    = 3'b100,
		ST_RECOVER = 3'b101
	} mlr_state_t;
endpackage

// ==== logic/mlr_recovery.sv ====
// Cable modem MAC message-loss recovery supervisor
//
// Behaviour
// - Sync lost only after full lost-SYNC interval
// - Sync lost: silent upstream, keep resyncing
// - No upstream before usable descriptor received
// - Param timer expiry: silent, scan next channel
// - Bad descriptor or count mismatch: silence, timer
// - That timer expiring resets the MAC
// - Transmit only inside granted interval
// - Lost map: silent for its span
// - Ranging response timeout retries request
// - Ranging retries exhausted resets the MAC
// - Registration response timeout retries request
// - Registration retries exhausted resets the MAC
// - Usable descriptor needs all profiles legal
// - Map count must match descriptor, whatever map_match_req says
// - Drop data packets failing CRC
// - Cut RF on overlong carrier
// - Drop management messages failing CRC
`timescale 1ns/1ns
`default_nettype none
module mlr_recovery
	import mlr_pkg::*;
#(
	parameter logic [31:0] LOST_SYNC = LOST_SYNC_CYC,
	parameter logic [31:0] T1_LOAD   = T1_CYC,
	parameter logic [31:0] RNG_TO    = RNG_RSP_CYC,
	parameter logic [31:0] REG_TO    = REG_RSP_CYC,
	parameter logic [31:0] BURST_MAX = MAX_BURST_CYC
)
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire mlr_rx_t    rx,
	input  wire logic       map_match_req,
	input  wire logic       data_rx,
	input  wire logic       data_crc_ok,
	input  wire logic       grant_active,
	input  wire logic       rng_req_sent,
	input  wire logic       reg_req_sent,
	input  wire logic       carrier_on,
	output logic            data_accept,
	output logic            tx_enable,
	output logic            rng_retry,
	output logic            reg_retry,
	output logic            scan_next,
	output logic            mac_reset,
	output logic            synced,
	output logic            rf_cut,
	output mlr_state_t      state
);
	mlr_state_t state_q;
	mlr_state_t state_d;
	logic       synced_q;
	logic       have_ucd_q;
	logic [7:0] ccc_q;
	logic       t1_recov_q;
	logic [3:0] rng_cnt_q;
	logic [3:0] reg_cnt_q;
	logic [3:0] rng_lim_q;
	logic [3:0] reg_lim_q;
	logic       rng_retry_q;
	logic       reg_retry_q;
	logic       scan_q;
	logic       mreset_q;
	logic       daccept_q;

	// Management frames with a bad CRC are treated as never received
	wire sync_ok   = rx.sync_rx    && rx.crc_ok;
	wire ucd_ok    = rx.ucd_rx     && rx.crc_ok;
	wire map_ok    = rx.map_rx     && rx.crc_ok;
	wire rng_ok    = rx.rng_rsp_rx && rx.crc_ok;
	wire reg_ok    = rx.reg_rsp_rx && rx.crc_ok;
	wire map_bad   = rx.map_lost || (rx.map_rx && !rx.crc_ok);
	wire ucd_good  = ucd_ok && rx.ucd_usable;
	wire ucd_unuse = ucd_ok && !rx.ucd_usable;
	wire cnt_miss  = map_ok && have_ucd_q && rx.map_ucd_cnt != ccc_q;

	// Timers
	logic sync_exp;
	logic sync_run;
	logic t1_exp;
	logic t1_run;
	logic rsp_exp;
	logic map_run;
	logic rsp_start;
	logic t1_start;
	wire  in_rng = state_q == ST_RANGE;
	wire  in_reg = state_q == ST_REG;

	// Lost-SYNC interval restarts on every good SYNC
	mlr_timer u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (sync_ok),
		.stop    (1'b0),
		.load    (LOST_SYNC),
		.running (sync_run),
		.expired (sync_exp)
	);

	assign t1_start = (state_d == ST_UPARAM && state_q != ST_UPARAM)
		|| (have_ucd_q && !t1_recov_q && (ucd_unuse || cnt_miss));
	mlr_timer u_t1 (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (t1_start),
		.stop    (ucd_good && state_q != ST_UPARAM && !cnt_miss),
		.load    (T1_LOAD),
		.running (t1_run),
		.expired (t1_exp)
	);

	// Response timer shared by ranging and registration
	assign rsp_start = (in_rng && rng_req_sent) || (in_reg && reg_req_sent);
	mlr_timer u_rsp (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (rsp_start),
		.stop    ((in_rng && rng_ok) || (in_reg && reg_ok)),
		.load    (in_rng ? RNG_TO : REG_TO),
		.running (),
		.expired (rsp_exp)
	);

	// Silence for the span a lost map would have described
	mlr_timer u_map (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (map_bad),
		.stop    (1'b0),
		.load    (rx.map_span),
		.running (map_run),
		.expired ()
	);

	mlr_carrier_wd u_wd (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.carrier_on (carrier_on),
		.limit      (BURST_MAX),
		.rf_cut     (rf_cut)
	);

	wire rng_exh = rsp_exp && in_rng && rng_cnt_q >= rng_lim_q;
	wire reg_exh = rsp_exp && in_reg && reg_cnt_q >= reg_lim_q;
	wire t1_fail = t1_exp && t1_recov_q;
	wire do_reset = t1_fail || rng_exh || reg_exh;
	wire ucd_accept = ucd_good && (!map_match_req || !cnt_miss);

	// Initialization sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_SCAN:    state_d = synced_q ? ST_UPARAM : ST_SCAN;
			ST_UPARAM:
			begin
				if (t1_exp)
					state_d = ST_SCAN;
				else if (ucd_accept)
					state_d = ST_RANGE;
			end
			ST_RANGE:   state_d = rng_ok ? ST_REG : ST_RANGE;
			ST_REG:     state_d = reg_ok ? ST_OPER : ST_REG;
			ST_OPER:    state_d = ST_OPER;
			ST_RECOVER: state_d = ST_SCAN;
			default:    state_d = ST_SCAN;
		endcase
		if (do_reset)
			state_d = ST_RECOVER;
		else if (!synced_q && state_q != ST_RECOVER)
			state_d = ST_SCAN;
	end

	// Main registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q     <= ST_SCAN;
			synced_q    <= 1'b0;
			have_ucd_q  <= 1'b0;
			ccc_q       <= 8'h00;
			t1_recov_q  <= 1'b0;
			rng_cnt_q   <= 4'h0;
			reg_cnt_q   <= 4'h0;
			rng_lim_q   <= RNG_RETRIES;
			reg_lim_q   <= REG_RETRIES;
			rng_retry_q <= 1'b0;
			reg_retry_q <= 1'b0;
			scan_q      <= 1'b0;
			mreset_q    <= 1'b0;
			daccept_q   <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			// Sync held until the full interval passes with no SYNC
			if (sync_ok)
				synced_q <= 1'b1;
			else if (sync_exp)
				synced_q <= 1'b0;
			if (ucd_ok)
				ccc_q <= rx.ucd_ccc;
			if (state_q == ST_UPARAM && state_d == ST_RANGE)
				have_ucd_q <= 1'b1;
			else if (state_d == ST_SCAN || state_d == ST_RECOVER)
				have_ucd_q <= 1'b0;
			if (have_ucd_q && (ucd_unuse || cnt_miss))
				t1_recov_q <= 1'b1;
			else if (ucd_good || !have_ucd_q)
				t1_recov_q <= 1'b0;
			rng_retry_q <= rsp_exp && in_rng && !rng_exh;
			reg_retry_q <= rsp_exp && in_reg && !reg_exh;
			if (!in_rng)
				rng_cnt_q <= 4'h0;
			else if (rsp_exp)
				rng_cnt_q <= rng_cnt_q + 4'h1;
			if (!in_reg)
				reg_cnt_q <= 4'h0;
			else if (rsp_exp)
				reg_cnt_q <= reg_cnt_q + 4'h1;
			scan_q    <= state_q != ST_SCAN && state_d == ST_SCAN;
			mreset_q  <= do_reset;
			daccept_q <= data_rx && data_crc_ok;
		end
	end

	// Upstream gate: every silence condition must be clear
	assign tx_enable = synced_q && have_ucd_q && !t1_recov_q
		&& state_q != ST_SCAN && state_q != ST_UPARAM
		&& state_q != ST_RECOVER && !map_run
		&& grant_active && !rf_cut;
	assign rng_retry   = rng_retry_q;
	assign reg_retry   = reg_retry_q;
	assign scan_next   = scan_q;
	assign mac_reset   = mreset_q;
	assign synced      = synced_q;
	assign data_accept = daccept_q;
	assign state       = state_q;

	sequence s_mismatch;
		have_ucd_q && !t1_recov_q && cnt_miss;
	endsequence
	property p_no_tx_unsynced;
		@(posedge ref_clk) disable iff (rst) !synced_q |-> !tx_enable;
	endproperty
	a_no_tx_unsynced: assert property (p_no_tx_unsynced)
		else $error("tx while unsynced");
	property p_sync_kept;
		@(posedge ref_clk) disable iff (rst)
			synced_q && sync_run |=> synced_q;
	endproperty
	a_sync_kept: assert property (p_sync_kept)
		else $error("sync dropped early");
	property p_no_grant;
		@(posedge ref_clk) disable iff (rst) !grant_active |-> !tx_enable;
	endproperty
	a_no_grant: assert property (p_no_grant)
		else $error("tx without grant");
	property p_map_silent;
		@(posedge ref_clk) disable iff (rst)
			map_bad && rx.map_span > 32'h2 |=> !tx_enable [*2];
	endproperty
	a_map_silent: assert property (p_map_silent)
		else $error("tx during lost map span");
	property p_mismatch;
		@(posedge ref_clk) disable iff (rst)
			s_mismatch |=> t1_recov_q && !tx_enable && t1_run;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("mismatch did not silence");
	property p_t1_reset;
		@(posedge ref_clk) disable iff (rst) t1_fail |=> mac_reset;
	endproperty
	a_t1_reset: assert property (p_t1_reset)
		else $error("T1 expiry no reset");
	property p_scan;
		@(posedge ref_clk) disable iff (rst)
			state_q == ST_UPARAM && t1_exp && !do_reset && synced_q
			|=> state_q == ST_SCAN && scan_next;
	endproperty
	a_scan: assert property (p_scan)
		else $error("no scan after T1");
	property p_rng_retry;
		@(posedge ref_clk) disable iff (rst)
			rsp_exp && in_rng && !rng_exh |=> rng_retry && !mac_reset;
	endproperty
	a_rng_retry: assert property (p_rng_retry)
		else $error("ranging retry missing");
	property p_rng_exh;
		@(posedge ref_clk) disable iff (rst)
			rng_exh |=> mac_reset && state_q == ST_RECOVER;
	endproperty
	a_rng_exh: assert property (p_rng_exh)
		else $error("ranging exhaustion no reset");
	property p_reg_exh;
		@(posedge ref_clk) disable iff (rst)
			reg_exh |=> mac_reset && state_q == ST_RECOVER;
	endproperty
	a_reg_exh: assert property (p_reg_exh)
		else $error("registration exhaustion no reset");
	property p_crc_drop;
		@(posedge ref_clk) disable iff (rst)
			data_rx && !data_crc_ok |=> !data_accept;
	endproperty
	a_crc_drop: assert property (p_crc_drop)
		else $error("bad CRC packet accepted");
endmodule
`default_nettype wire

// ==== logic/mlr_timer.sv ====
// Loadable down-counting timer with expiry pulse
`timescale 1ns/1ns
`default_nettype none
module mlr_timer
	import mlr_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic          stop,
	input  wire logic [TW-1:0] load,
	output logic               running,
	output logic               expired
);
	logic [TW-1:0] cnt_q;
	logic          run_q;
	logic          exp_q;

	// Start wins over stop so a restart is never missed
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end
		else
		begin
			exp_q <= 1'b0;
			if (start)
			begin
				cnt_q <= load;
				run_q <= 1'b1;
			end
			else if (stop)
				run_q <= 1'b0;
			else if (run_q)
			begin
				if (cnt_q <= 32'h1)
				begin
					run_q <= 1'b0;
					exp_q <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 32'h1;
			end
		end
	end
	assign running = run_q;
	assign expired = exp_q;
endmodule
`default_nettype wire

// ==== test/mlr_headend.sv ====
// Headend model sending downstream management messages
`timescale 1ns/1ns
`default_nettype none
module mlr_headend
	import mlr_pkg::*;
(
	input  wire logic ref_clk,
	output mlr_rx_t   rx
);
	mlr_rx_t pend;
	logic    auto_sync;
	int      n;
	initial
	begin
		rx = '0;
		pend = '0;
		auto_sync = 0;
		n = 0;
	end
	// Kinds: 0 sync, 1 good ucd, 2 unusable ucd, 3 map, 4 lost map,
	// 5 ranging rsp, 6 registration rsp
	task automatic msg(input int k, input logic ok, input logic [7:0] v);
		pend.sync_rx = (k == 0);
		pend.ucd_rx = (k == 1 || k == 2);
		pend.ucd_usable = (k == 1);
		pend.map_rx = (k == 3);
		pend.map_lost = (k == 4);
		pend.rng_rsp_rx = (k == 5);
		pend.reg_rsp_rx = (k == 6);
		pend.crc_ok = ok;
		pend.ucd_ccc = v;
		pend.map_ucd_cnt = v;
		pend.map_span = 32'(v);
		@(posedge ref_clk);
		#2;
	endtask
	// Channel-change request toward a modem that never answers
	int   ucc_tries = 0;
	logic ucc_unreach = 0;
	task automatic ucc(input int retries, input int to);
		ucc_tries = 0;
		ucc_unreach = 0;
		while (!ucc_unreach)
		begin
			ucc_tries++;
			repeat (to) @(posedge ref_clk);
			if (ucc_tries > retries)
				ucc_unreach = 1;
		end
	endtask
	// One message per cycle; periodic sync only in otherwise idle slots
	always @(posedge ref_clk)
	begin
		#1;
		n = n + 1;
		rx = pend;
		if (auto_sync && pend == '0 && n % 16 == 0)
			rx = '{sync_rx: 1, crc_ok: 1, default: '0};
		if (!rx.ucd_rx && !rx.map_rx)
			rx.ucd_ccc = 8'($urandom); // Stale payload is not held
		pend = '0;
	end
endmodule
`default_nettype wire

// ==== test/test_mlr_recovery.sv ====
// Self-checking bench for the message-loss recovery supervisor
`timescale 1ns/1ns
`default_nettype none
module test_mlr_recovery;
	import mlr_pkg::*;
	localparam int LS = 40;
	localparam int T1 = 30;
	localparam int TO = 20;
	localparam int BM = 25;
	logic       ref_clk = 0;
	logic       rst = 1;
	mlr_rx_t    rx;
	logic       map_match_req = 0;
	logic       data_rx = 0;
	logic       data_crc_ok = 0;
	logic       grant_active = 0;
	logic       rng_req_sent = 0;
	logic       reg_req_sent = 0;
	logic       carrier_on = 0;
	logic       data_accept, tx_enable, rng_retry, reg_retry;
	logic       scan_next, mac_reset, synced, rf_cut;
	mlr_state_t state;
	int         err_count = 0;
	int         check_count = 0;
	int         cyc = 0;
	int         c_rng = 0, c_reg = 0, c_scan = 0, c_rst = 0, c_acc = 0;
	int         e_acc = 0, b_rst, i;
	always #5 ref_clk = ~ref_clk;
	mlr_headend hd (.ref_clk(ref_clk), .rx(rx));
	mlr_recovery #(.LOST_SYNC(32'd40), .T1_LOAD(32'd30), .RNG_TO(32'd20),
		.REG_TO(32'd20), .BURST_MAX(32'd25)) dut (
		.ref_clk(ref_clk), .rst(rst), .rx(rx),
		.map_match_req(map_match_req),
		.data_rx(data_rx), .data_crc_ok(data_crc_ok),
		.grant_active(grant_active), .rng_req_sent(rng_req_sent),
		.reg_req_sent(reg_req_sent), .carrier_on(carrier_on),
		.data_accept(data_accept), .tx_enable(tx_enable),
		.rng_retry(rng_retry), .reg_retry(reg_retry),
		.scan_next(scan_next), .mac_reset(mac_reset), .synced(synced),
		.rf_cut(rf_cut), .state(state));
	// Pulse counters; also the hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		c_rng += (rng_retry === 1);
		c_reg += (reg_retry === 1);
		c_scan += (scan_next === 1);
		c_rst += (mac_reset === 1);
		c_acc += (data_accept === 1);
		if (cyc == 6000)
		begin
			err_count++;
			end_sim();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_st(input mlr_state_t s);
		for (int k = 0; k < 300 && state !== s; k++)
			tick(1);
		chk(32'(state), 32'(s));
	endtask
	task automatic req(input bit rng);
		rng_req_sent = rng;
		reg_req_sent = !rng;
		tick(1);
		rng_req_sent = 0;
		reg_req_sent = 0;
	endtask
	// Walk up to operational, refusing bad descriptors on the way
	task automatic go_oper();
		wait_st(ST_UPARAM);
		hd.msg(2, 1, 8'h05);
		hd.msg(1, 0, 8'h05);
		tick(3);
		chk(32'(state), 32'(ST_UPARAM));
		chk(32'(tx_enable), 0);
		hd.msg(1, 1, 8'h05);
		wait_st(ST_RANGE);
		hd.msg(5, 1, 8'h00);
		wait_st(ST_REG);
		hd.msg(6, 1, 8'h00);
		wait_st(ST_OPER);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(76757));
		tick(10);
		rst = 0;
		chk(32'(state), 32'(ST_SCAN));
		grant_active = 1;
		hd.msg(0, 1, 8'h00);
		tick(3);
		chk(32'(synced), 1);
		chk(32'(tx_enable), 0);
		tick(T1 + 3);
		chk(32'(c_scan), 1);
		chk(32'(synced), 1);
		tick(LS - T1);
		chk(32'(synced), 0);
		$display("test sync and scan done");
		hd.auto_sync = 1;
		go_oper();
		chk(32'(tx_enable), 1);
		grant_active = 0;
		tick(1);
		chk(32'(tx_enable), 0);
		grant_active = 1;
		hd.msg(4, 0, 8'd12);
		tick(4);
		chk(32'(tx_enable), 0);
		tick(14);
		chk(32'(tx_enable), 1);
		b_rst = c_rst;
		hd.msg(3, 1, 8'h06);
		tick(1);
		chk(32'(tx_enable), 0);
		tick(T1 + 6);
		chk(32'(c_rst - b_rst), 1);
		$display("test grants and maps done");
		wait_st(ST_UPARAM);
		hd.msg(1, 1, 8'h05);
		wait_st(ST_RANGE);
		b_rst = c_rst;
		for (i = 0; i < 16; i++)
		begin
			req(1);
			tick(TO + 4);
		end
		chk(32'(c_rng), 15);
		chk(32'(c_rst - b_rst), 1);
		go_oper();
		hd.auto_sync = 0;
		tick(LS + 10);
		chk(32'(synced), 0);
		chk(32'(tx_enable), 0);
		chk(32'(state), 32'(ST_SCAN));
		hd.auto_sync = 1;
		$display("test ranging and sync loss done");
		map_match_req = 1;
		wait_st(ST_UPARAM);
		hd.msg(1, 1, 8'h05);
		wait_st(ST_RANGE);
		hd.msg(5, 1, 8'h00);
		wait_st(ST_REG);
		b_rst = c_rst;
		for (i = 0; i < 4; i++)
		begin
			req(0);
			tick(TO + 4);
		end
		chk(32'(c_reg), 3);
		chk(32'(c_rst - b_rst), 1);
		$display("test registration done");
		for (i = 0; i < 16; i++)
		begin
			data_crc_ok = 1'($urandom);
			data_rx = 1;
			e_acc += data_crc_ok;
			tick(1);
			data_rx = 0;
			tick(1);
		end
		chk(32'(c_acc), 32'(e_acc));
		carrier_on = 1;
		tick(BM - 5);
		chk(32'(rf_cut), 0);
		tick(10);
		chk(32'(rf_cut), 1);
		carrier_on = 0;
		hd.ucc(3, 5);
		chk(32'(hd.ucc_tries), 4);
		chk(32'(hd.ucc_unreach), 1);
		$display("test data and carrier done");
		end_sim();
	end
endmodule
`default_nettype wire
